// ==== core/gpef_top.sv ====
// Purpose: GPIO ports E (8 bits) and F (7 bits) with APB register access
// Assumes: pclk 40 MHz, presetn async active low, pins synchronous-sampled via two flops
// Notes:   Zero-wait-state APB slave, unmapped addresses read zero and raise pslverr
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
`include "gpef_map.svh"

module gpef_top #(
	parameter int E_WIDTH = `GPEF_E_WIDTH,
	parameter int F_WIDTH = `GPEF_F_WIDTH
) (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Port E pins and mux select (1 = GPIO)
	input  wire logic [E_WIDTH-1:0] port_e_in,
	output logic      [E_WIDTH-1:0] port_e_out,
	output logic      [E_WIDTH-1:0] port_e_oe,
	input  wire logic [E_WIDTH-1:0] port_e_gpio_sel,
	// Port F pins and mux select (1 = GPIO)
	input  wire logic [F_WIDTH-1:0] port_f_in,
	output logic      [F_WIDTH-1:0] port_f_out,
	output logic      [F_WIDTH-1:0] port_f_oe,
	input  wire logic [F_WIDTH-1:0] port_f_gpio_sel
);

	// Whole state of the top level
	typedef struct packed {
		logic [E_WIDTH-1:0] e_data;
		logic [E_WIDTH-1:0] e_dir;
		logic [F_WIDTH-1:0] f_data;
		logic [F_WIDTH-1:0] f_dir;
		logic [31:0]        rdata;
		logic               ready;
		logic               slverr;
		gpef_pkg::gpef_state_t state;
	} gpef_top_st_t;

	gpef_top_st_t           st_q;
	gpef_top_st_t           st_d;
	gpef_pkg::gpef_apb_req_t req;
	logic [E_WIDTH-1:0]     e_sync;
	logic [F_WIDTH-1:0]     f_sync;
	logic [E_WIDTH-1:0]     e_read;
	logic [F_WIDTH-1:0]     f_read;
	logic                   setup;
	logic                   hit;

	// Bundle the APB request
	assign req.psel    = psel;
	assign req.penable = penable;
	assign req.pwrite  = pwrite;
	assign req.paddr   = paddr;
	assign req.pwdata  = pwdata;

	// Synchronise input pins before readback
	gpef_sync #(
		.WIDTH (E_WIDTH)
	) u_sync_e (
		.pclk      (pclk),
		.presetn   (presetn),
		.pin_async (port_e_in),
		.pin_sync  (e_sync)
	);

	gpef_sync #(
		.WIDTH (F_WIDTH)
	) u_sync_f (
		.pclk      (pclk),
		.presetn   (presetn),
		.pin_async (port_f_in),
		.pin_sync  (f_sync)
	);

	// Readback mux per bit: output bits give stored data, inputs the pin
	generate
		for (genvar i = 0; i < E_WIDTH; i++) begin : g_e_rd
			assign e_read[i] = st_q.e_dir[i] ? st_q.e_data[i] : e_sync[i];
		end
		for (genvar j = 0; j < F_WIDTH; j++) begin : g_f_rd
			assign f_read[j] = st_q.f_dir[j] ? st_q.f_data[j] : f_sync[j];
		end
	endgenerate

	// Setup phase of a new transfer and address decode
	assign setup = req.psel & ~req.penable;
	always_comb begin
		unique case (req.paddr)
			`GPEF_OFS_E_DATA, `GPEF_OFS_F_DATA,
			`GPEF_OFS_E_DIR,  `GPEF_OFS_F_DIR: hit = 1'b1;
			default:                             hit = 1'b0;
		endcase
	end

	// APB slave: register in setup, answer one cycle later in access phase
	always_comb begin
		st_d        = st_q;
		st_d.ready  = 1'b0;
		st_d.slverr = 1'b0;
		unique case (st_q.state)
			gpef_pkg::GPEF_IDLE: begin
				if (setup) begin
					st_d.state  = gpef_pkg::GPEF_ANSWER;
					st_d.ready  = 1'b1;
					st_d.slverr = ~hit;
					st_d.rdata  = 32'h0000_0000;
					if (!req.pwrite) begin
						unique case (req.paddr)
							`GPEF_OFS_E_DATA: st_d.rdata[E_WIDTH-1:0] = e_read;
							`GPEF_OFS_F_DATA: st_d.rdata[F_WIDTH-1:0] = f_read;
							`GPEF_OFS_E_DIR:  st_d.rdata[E_WIDTH-1:0] = st_q.e_dir;
							`GPEF_OFS_F_DIR:  st_d.rdata[F_WIDTH-1:0] = st_q.f_dir;
							default:          st_d.rdata = 32'h0000_0000;
						endcase
					end
				end
			end
			gpef_pkg::GPEF_ANSWER: begin
				// Access phase completes this edge; write takes effect here
				st_d.state = gpef_pkg::GPEF_IDLE;
				if (req.psel && req.penable && req.pwrite) begin
					unique case (req.paddr)
						`GPEF_OFS_E_DATA: st_d.e_data = req.pwdata[E_WIDTH-1:0];
						`GPEF_OFS_F_DATA: st_d.f_data = req.pwdata[F_WIDTH-1:0];
						`GPEF_OFS_E_DIR:  st_d.e_dir  = req.pwdata[E_WIDTH-1:0];
						`GPEF_OFS_F_DIR:  st_d.f_dir  = req.pwdata[F_WIDTH-1:0];
						default:          st_d.e_data = st_q.e_data;
					endcase // Upper bits dropped
				end
			end
			default: begin
				st_d.state = gpef_pkg::GPEF_IDLE;
			end
		endcase
	end

	// State register, reset clears all fields but state, which loads GPEF_IDLE
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q.e_data <= `GPEF_E_RESET;
			st_q.e_dir  <= `GPEF_E_RESET;
			st_q.f_data <= `GPEF_F_RESET;
			st_q.f_dir  <= `GPEF_F_RESET;
			st_q.rdata  <= 32'h0000_0000;
			st_q.ready  <= 1'b0;
			st_q.slverr <= 1'b0;
			st_q.state  <= gpef_pkg::GPEF_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// Pin drivers gated by direction and GPIO selection
	gpef_pin_ctl #(
		.WIDTH (E_WIDTH)
	) u_pin_e (
		.pclk     (pclk),
		.presetn  (presetn),
		.data     (st_q.e_data),
		.dir      (st_q.e_dir),
		.gpio_sel (port_e_gpio_sel),
		.pin_out  (port_e_out),
		.pin_oe   (port_e_oe)
	);

	gpef_pin_ctl #(
		.WIDTH (F_WIDTH)
	) u_pin_f (
		.pclk     (pclk),
		.presetn  (presetn),
		.data     (st_q.f_data),
		.dir      (st_q.f_dir),
		.gpio_sel (port_f_gpio_sel),
		.pin_out  (port_f_out),
		.pin_oe   (port_f_oe)
	);

	// Bus answer outputs straight from flops
	assign prdata  = st_q.rdata;
	assign pready  = st_q.ready;
	assign pslverr = st_q.slverr;

endmodule

// ==== shared/gpef_map.svh ====
// Purpose: Register offsets, field positions, reset values for GPIO ports E and F
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef GPEF_MAP_SVH
`define GPEF_MAP_SVH

// Register byte offsets
`define GPEF_OFS_E_DATA     8'h00
`define GPEF_OFS_F_DATA     8'h04
`define GPEF_OFS_E_DIR      8'h08
`define GPEF_OFS_F_DIR      8'h0C

// Field widths and positions
`define GPEF_E_WIDTH        8
`define GPEF_F_WIDTH        7
`define GPEF_FIELD_LSB      0

// Reset values
`define GPEF_E_RESET        8'h00
`define GPEF_F_RESET        7'h00

// Synchroniser depth
`define GPEF_SYNC_STAGES    2

`endif

// ==== shared/gpef_pkg.sv ====
// Purpose: Types for GPIO ports E and F
// Assumes: gpef_map.svh supplies the numbers
// Notes:   Types only
`include "gpef_map.svh"

package gpef_pkg;

	// APB request as seen by the slave
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} gpef_apb_req_t;

	// Register state of one port
	typedef struct packed {
		logic [`GPEF_E_WIDTH-1:0] data;
		logic [`GPEF_E_WIDTH-1:0] dir;
	} gpef_e_regs_t;

	typedef struct packed {
		logic [`GPEF_F_WIDTH-1:0] data;
		logic [`GPEF_F_WIDTH-1:0] dir;
	} gpef_f_regs_t;

	// Slave access phase states
	typedef enum logic [1:0] {
		GPEF_IDLE   = 2'b01,
		GPEF_ANSWER = 2'b10
	} gpef_state_t;

endpackage

// ==== core/gpef_sync.sv ====
// Purpose: Two-flop synchroniser for a bank of pin inputs
// Assumes: Single clock pclk, async active-low reset
// Notes:   First stage is read only by the second stage
`timescale 1ns/100ps

module gpef_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Pin levels in and synchronised out
	input  wire logic [WIDTH-1:0] pin_async,
	output logic      [WIDTH-1:0] pin_sync
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} gpef_sync_st_t;

	gpef_sync_st_t st_q;
	gpef_sync_st_t st_d;

	// Shift pins through two stages
	always_comb begin
		st_d      = st_q;
		st_d.meta = pin_async;
		st_d.sync = st_q.meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign pin_sync = st_q.sync;

endmodule

// ==== core/gpef_pin_ctl.sv ====
// Purpose: Per-pin output enable gating by direction and GPIO mux selection
// Assumes: data and dir come from registers in the top module, gpio_sel straight from its input ports
// Notes:   Output is registered so top outputs come from flip-flops
`timescale 1ns/100ps

module gpef_pin_ctl #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Register state and mux select
	input  wire logic [WIDTH-1:0] data,
	input  wire logic [WIDTH-1:0] dir,
	input  wire logic [WIDTH-1:0] gpio_sel,
	// Pin drive
	output logic      [WIDTH-1:0] pin_out,
	output logic      [WIDTH-1:0] pin_oe
);

	typedef struct packed {
		logic [WIDTH-1:0] out;
		logic [WIDTH-1:0] oe;
	} gpef_pin_st_t;

	gpef_pin_st_t st_q;
	gpef_pin_st_t st_d;

	// Enable a driver only for GPIO-selected output pins
	always_comb begin
		st_d = st_q;
		for (int i = 0; i < WIDTH; i++) begin
			st_d.oe[i]  = dir[i] & gpio_sel[i];
			st_d.out[i] = data[i] & dir[i] & gpio_sel[i];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign pin_out = st_q.out;
	assign pin_oe  = st_q.oe;

endmodule

// ==== testbench/gpef_properties.sv ====
// Purpose: Port-level properties of GPIO ports E and F
// Assumes: One pclk domain; mux select all-GPIO around drive checks
// Notes:   Bound to gpef_top below
`timescale 1ns/100ps
module gpef_properties #(
	parameter int E_WIDTH = 8,
	parameter int F_WIDTH = 7
) (
	// Clock, reset and APB
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [7:0]         paddr,
	input wire logic [31:0]        pwdata,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	// Pin drive and mux select
	input wire logic [E_WIDTH-1:0] port_e_out,
	input wire logic [E_WIDTH-1:0] port_e_oe,
	input wire logic [E_WIDTH-1:0] port_e_gpio_sel,
	input wire logic [F_WIDTH-1:0] port_f_out,
	input wire logic [F_WIDTH-1:0] port_f_oe,
	input wire logic [F_WIDTH-1:0] port_f_gpio_sel
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Write accepted in its access cycle
	sequence wr_at(logic [7:0] a);
		psel && penable && pready && pwrite && paddr == a;
	endsequence
	// Drive only where the pin was selected as GPIO
	e_oe_gate_a: assert property ((port_e_oe & ~$past(port_e_gpio_sel)) == '0)
		else $error("port E driven while not GPIO");
	f_oe_gate_a: assert property ((port_f_oe & ~$past(port_f_gpio_sel)) == '0)
		else $error("port F driven while not GPIO");
	out_off_a: assert property ((port_e_out & ~port_e_oe) == '0 && (port_f_out & ~port_f_oe) == '0)
		else $error("drive value on a disabled pin");
	// Register writes reach the pins two edges later
	e_dir_drive_a: assert property (wr_at(8'h08) ##0 port_e_gpio_sel == '1 |-> ##2
		port_e_oe == $past(pwdata[E_WIDTH-1:0], 2)) else $error("port E enable mismatch");
	f_dir_drive_a: assert property (wr_at(8'h0C) ##0 port_f_gpio_sel == '1 |-> ##2
		port_f_oe == $past(pwdata[F_WIDTH-1:0], 2)) else $error("port F enable mismatch");
	e_data_drive_a: assert property (wr_at(8'h00) ##0 port_e_gpio_sel == '1 |-> ##2
		port_e_out == ($past(pwdata[E_WIDTH-1:0], 2) & port_e_oe)) else $error("port E drive mismatch");
	rd_upper_zero_a: assert property (pready && !pwrite |->
		prdata[31:8] == '0 && !(paddr[2] && prdata[7])) else $error("reserved read bits set");
	reset_clear_a: assert property ($rose(presetn) |-> port_e_oe == '0 && port_f_oe == '0)
		else $error("pin driven after reset");
endmodule

bind gpef_top gpef_properties #(.E_WIDTH(E_WIDTH), .F_WIDTH(F_WIDTH)) i_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.port_e_out(port_e_out), .port_e_oe(port_e_oe), .port_e_gpio_sel(port_e_gpio_sel),
	.port_f_out(port_f_out), .port_f_oe(port_f_oe), .port_f_gpio_sel(port_f_gpio_sel));

// ==== testbench/gpef_pins.sv ====
// Purpose: Pin levels seen by ports E and F
// Assumes: Port drive wins where enabled
// Notes:   Undriven pins take the far-side level
`timescale 1ns/100ps
module gpef_pins (
	// Port drive
	input  wire logic [7:0] e_out,
	input  wire logic [7:0] e_oe,
	input  wire logic [6:0] f_out,
	input  wire logic [6:0] f_oe,
	// Far-side levels
	input  wire logic [7:0] e_ext,
	input  wire logic [6:0] f_ext,
	// Resolved pins
	output logic      [7:0] e_in,
	output logic      [6:0] f_in
);
	// Each pin resolves to its enabled driver
	assign e_in = (e_out & e_oe) | (e_ext & ~e_oe);
	assign f_in = (f_out & f_oe) | (f_ext & ~f_oe);
endmodule

// ==== testbench/gpio_ports_e_f_tb.sv ====
// Purpose: Register and pin tests of GPIO ports E and F
// Assumes: Zero-wait APB slave, pins resolved by gpef_pins
// Notes:   Pin checks wait three edges for sync and drive flops
`timescale 1ns/100ps
module gpio_ports_e_f_tb;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = '0, e_ext = 8'h3C, e_sel = '1, e_in, e_out, e_oe;
	logic [6:0]  f_ext = 7'h2A, f_sel = '1, f_in, f_out, f_oe;
	logic [31:0] pwdata = '0, prdata, r;
	logic        pready, slverr, err;
	int          miscompares = 0, checks_done = 0;
	// Clock
	always #12.5 pclk = ~pclk;
	gpef_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(slverr), .port_e_in(e_in), .port_e_out(e_out), .port_e_oe(e_oe),
		.port_e_gpio_sel(e_sel), .port_f_in(f_in), .port_f_out(f_out), .port_f_oe(f_oe),
		.port_f_gpio_sel(f_sel));
	gpef_pins i_pins (.e_out(e_out), .e_oe(e_oe), .f_out(f_out), .f_oe(f_oe),
		.e_ext(e_ext), .f_ext(f_ext), .e_in(e_in), .f_in(f_in));
	// One APB transfer, held until pready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int   n;
		logic done;
		n = 0;
		done = 1'b0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Answer is looked at mid-cycle, settled for the next rising edge
		do begin
			@(negedge pclk);
			n++;
			done = (pready === 1'b1);
			r = prdata;
			err = slverr;
			@(posedge pclk);
		end while (!done && n < 20);
		if (!done) miscompares++;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge, so a following call never re-raises psel in this step
		@(posedge pclk);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		// Let the pin synchronisers fill after reset
		repeat (2) @(posedge pclk);
		for (int i = 0; i < 5; i++) begin
			xfer(1'b0, 8'(4 * i), '0);
			chk(r, (i == 0) ? 32'h3C : (i == 1) ? 32'h2A : 32'h0);
			chk({31'h0, err}, (i == 4) ? 32'h1 : 32'h0);
		end
		$display("test reset values done");
		xfer(1'b1, 8'h08, 32'h000000F0);
		xfer(1'b0, 8'h00, '0);
		chk(r, 32'h0C);
		xfer(1'b1, 8'h00, 32'h000000A5);
		repeat (3) @(posedge pclk);
		chk({24'h0, e_oe}, 32'hF0);
		chk({24'h0, e_out}, 32'hA0);
		xfer(1'b0, 8'h00, '0);
		chk(r, 32'hAC);
		xfer(1'b0, 8'h08, '0);
		chk(r, 32'hF0);
		$display("test port E done");
		xfer(1'b1, 8'h0C, 32'h0000000F);
		xfer(1'b1, 8'h04, 32'h00000055);
		repeat (3) @(posedge pclk);
		chk({25'h0, f_oe}, 32'h0F);
		chk({25'h0, f_out}, 32'h05);
		xfer(1'b0, 8'h04, '0);
		chk(r, 32'h25);
		$display("test port F done");
		e_sel <= 8'h3F;
		f_sel <= 7'h0C;
		repeat (3) @(posedge pclk);
		chk({24'h0, e_oe}, 32'h30);
		chk({25'h0, f_oe}, 32'h0C);
		e_sel <= '1;
		f_sel <= '1;
		$display("test mux select done");
		xfer(1'b1, 8'h08, '0);
		e_ext <= 8'hC3;
		repeat (3) @(posedge pclk);
		chk({16'h0, e_oe, e_out}, '0);
		xfer(1'b0, 8'h00, '0);
		chk(r, 32'hC3);
		$display("test input mode done");
		results();
	end
	// Watchdog
	initial begin
		#200000;
		miscompares++;
		results();
	end
endmodule
